//--- inc/smrec_pkg.sv
// package: offsets, field positions, reset values and timing counts for the
// system memory, reset and error-correction control register bank
// assumes: included before the interface and design modules
package smrec_pkg;
   localparam logic [7:0]  OFS_MEM_CTRL     = 8'h28;
   localparam logic [7:0]  OFS_MEM_ZERO     = 8'h2C;
   localparam logic [7:0]  OFS_SYS_STATUS   = 8'h40;
   localparam logic [7:0]  OFS_RST_SECOND   = 8'h44;
   localparam logic [7:0]  OFS_GATE_SECOND  = 8'h48;
   localparam logic [7:0]  OFS_EVENT_EN     = 8'h4C;
   localparam logic [7:0]  OFS_REVISION     = 8'h50;
   localparam logic [7:0]  OFS_SYS_IRQ_EN   = 8'h54;
   localparam logic [7:0]  OFS_ERR_FLAG     = 8'h64;
   localparam logic [7:0]  OFS_CORR_FLAG    = 8'h68;
   localparam logic [7:0]  OFS_ERR_IRQ_EN   = 8'h6C;
   localparam logic [7:0]  OFS_ERR_ADDR     = 8'h70;
   localparam logic [7:0]  OFS_SCRATCH      = 8'h80;

   localparam int          BIT_BANK0_ECC_EN = 16;
   localparam int          WAIT_LSB         = 0;
   localparam int          WAIT_W           = 3;
   localparam logic [2:0]  WAIT_RESET       = 3'h5;
   localparam int          ZERO_W           = 7;
   localparam int          BIT_TX_EVENT     = 2;
   localparam int          BIT_DMA_EVENT    = 0;
   localparam int          BIT_SECOND_CORE  = 31;
   // writable peripheral reset trigger bits (25,24,20,19,16,11,10,9,7,1,0)
   localparam logic [31:0] RST_MASK         = 32'h0319_0E83;
   // implemented clock gate bits (31,27,24,23,16,15,14,13,9,2,1)
   localparam logic [31:0] GATE_MASK        = 32'h8981_E206;
   localparam logic [31:0] GATE_RESET       = 32'h8981_E206;
   localparam logic [31:0] SCRATCH_RESET    = 32'h0000_0000;
   localparam int          BIT_TAG_ERR      = 31;
   localparam int          BIT_TAG_BANK     = 30;
   localparam int          BIT_DATA_ERR     = 15;
   localparam int          BIT_DATA_BANK    = 14;

   // minimum pulse width for a peripheral reset, in ns
   localparam int          RST_PULSE_NS     = 160;
   localparam int          CLK_PERIOD_NS    = 40;
   localparam int          RST_PULSE_CYC    = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // arbitrary neutral revision code
   localparam logic [15:0] REVISION_DEFAULT = 16'h0010;

   typedef enum logic [1:0] {
      SMREC_ERR_NONE,
      SMREC_ERR_RAM,
      SMREC_ERR_CACHE
   } smrec_err_src_t;
endpackage

//--- inc/smrec_job_if.sv
// interface: start/done job handshake between register bank and workers
// assumes: one clock, workers answer each start with a later done pulse
`timescale 1ns/1ps
interface smrec_job_if #(parameter int N = 7);
   logic [N-1:0] start;
   logic [N-1:0] done;
   modport bank   (output start, input done);
   modport worker (input start, output done);
endinterface

//--- src/smrec_pulse_timer.sv
// module: one reset pulse timer per peripheral reset trigger bit
// assumes: starts are one-cycle pulses on the shared system clock
`timescale 1ns/1ps
module smrec_pulse_timer #(
   parameter int N   = 32,
   parameter int CYC = smrec_pkg::RST_PULSE_CYC
) (
   input  wire logic    i_clk,
   input  wire logic    i_srst,
   smrec_job_if.worker  job,
   output logic [N-1:0] o_active
);
   localparam int CW = $clog2(CYC + 1);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_tmr
         logic [CW-1:0] cnt_reg;
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               cnt_reg <= '0;
            end else if (job.start[g]) begin
               cnt_reg <= CW'(CYC);
            end else if (cnt_reg != '0) begin
               cnt_reg <= cnt_reg - CW'(1);
            end
         end
         assign o_active[g] = (cnt_reg != '0);
         assign job.done[g] = (cnt_reg == CW'(1));
      end
   endgenerate
endmodule

//--- src/smrec_zero_engine.sv
// module: memory zeroization sweeps, one address counter per memory
// assumes: start pulses come from the register bank; sweep length is a parameter
`timescale 1ns/1ps
module smrec_zero_engine #(
   parameter int N     = smrec_pkg::ZERO_W,
   parameter int WORDS = 64
) (
   input  wire logic    i_clk,
   input  wire logic    i_srst,
   smrec_job_if.worker  job,
   output logic [N-1:0] o_busy
);
   localparam int AW = $clog2(WORDS + 1);
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_mem
         logic [AW-1:0] left_reg;
         always_ff @(posedge i_clk) begin
            if (i_srst) begin
               left_reg <= '0;
            end else if (job.start[g] && left_reg == '0) begin
               left_reg <= AW'(WORDS);
            end else if (left_reg != '0) begin
               left_reg <= left_reg - AW'(1);
            end
         end
         assign o_busy[g]   = (left_reg != '0);
         assign job.done[g] = (left_reg == AW'(1));
      end
   endgenerate
endmodule

//--- src/smrec_regbank.sv
// file: system memory, reset and error-correction control register bank
// assumes: APB slave on a 25 MHz system clock, synchronous active-high reset
//
// What this block does
// (R1) bit 16 enables bank zero correction
// (R2) field 2:0 sets flash wait states
// (R3) software keeps two waits on internal oscillators
// (R4) zeroize bits start clears, read busy
// (R5) status bit 0 shows debug lock
// (R6) reset-two bits trigger peripheral resets
// (R7) bit 31 resets secondary core
// (R8) clock gate bit stops clock, blocks access
// (R9) clock gate bit assignments as listed
// (R10) event bit 2 lets transmit event wake
// (R11) event bit 0 lets count-zero raise receive-event
// (R12) revision low half, upper bits zero
// (R13) lock interrupt while enabled and locked
// (R14) error flag set, write one clears
// (R15) correctable flag set, write one clears
// (R16) error interrupt when enabled on error
// (R17) cache tag error fields in upper half
// (R18) cache data error fields in lower half
// (R19) bank zero error captures bus address
// (R20) scratch word stores 32 bits
// (R21) reset bits read one until done
// (R22) error address holds first RAM error; cache errors load it only while the error flag is clear
`timescale 1ns/1ps
module smrec_regbank #(
   parameter logic [15:0] REVISION   = smrec_pkg::REVISION_DEFAULT,
   parameter int          ZERO_WORDS = 64
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_debug_locked,
   input  wire logic        i_ram_err,
   input  wire logic        i_ram_corr,
   input  wire logic [31:0] i_ram_err_addr,
   input  wire logic        i_cache_err,
   input  wire logic        i_cache_tag_err,
   input  wire logic        i_cache_tag_bank,
   input  wire logic [13:0] i_cache_tag_addr,
   input  wire logic        i_cache_data_err,
   input  wire logic        i_cache_data_bank,
   input  wire logic [13:0] i_cache_data_addr,
   input  wire logic        i_transmit_event,
   input  wire logic        i_count_reached_zero,
   output logic             o_bank_zero_correction_enable,
   output logic [2:0]       o_flash_wait_states,
   output logic [6:0]       o_zero_busy,
   output logic [31:0]      o_periph_reset,
   output logic [31:0]      o_periph_clock_gate,
   output logic             o_wake_transmit_event,
   output logic             o_receive_event,
   output logic             o_debug_lock_irq,
   output logic             o_ram_error_irq
);
   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   function automatic logic known(input logic [7:0] a);
      case (a)
         smrec_pkg::OFS_MEM_CTRL, smrec_pkg::OFS_MEM_ZERO, smrec_pkg::OFS_SYS_STATUS,
         smrec_pkg::OFS_RST_SECOND, smrec_pkg::OFS_GATE_SECOND, smrec_pkg::OFS_EVENT_EN,
         smrec_pkg::OFS_REVISION, smrec_pkg::OFS_SYS_IRQ_EN, smrec_pkg::OFS_ERR_FLAG,
         smrec_pkg::OFS_CORR_FLAG, smrec_pkg::OFS_ERR_IRQ_EN, smrec_pkg::OFS_ERR_ADDR,
         smrec_pkg::OFS_SCRATCH: known = 1'b1;
         default: known = 1'b0;
      endcase
   endfunction

   logic        access;
   logic        wr;
   logic        rd;
   logic [31:0] rdata_next;
   logic [31:0] prdata_reg;

   assign access    = i_psel && i_penable;
   assign wr        = access && i_pwrite && known(i_paddr);
   assign rd        = access && !i_pwrite;
   assign o_pready  = 1'b1;
   assign o_pslverr = access && !known(i_paddr);

   function automatic logic wr_at(input logic [7:0] ofs);
      wr_at = wr && (i_paddr == ofs);
   endfunction

   // ----------------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------------
   logic              ecc_en_reg;
   logic [2:0]        wait_reg;
   logic [2:0]        evt_reg;
   logic              sys_ie_reg;
   logic              err_ie_reg;
   logic [31:0]       scratch_reg;
   logic [31:0]       gate_reg;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ecc_en_reg <= 1'b0;
         wait_reg   <= smrec_pkg::WAIT_RESET;
      end else if (wr_at(smrec_pkg::OFS_MEM_CTRL)) begin
         ecc_en_reg <= i_pwdata[smrec_pkg::BIT_BANK0_ECC_EN]; // R1
         wait_reg   <= i_pwdata[smrec_pkg::WAIT_LSB +: smrec_pkg::WAIT_W]; // R2
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         evt_reg <= 3'h0;
      end else if (wr_at(smrec_pkg::OFS_EVENT_EN)) begin
         evt_reg[smrec_pkg::BIT_TX_EVENT]  <= i_pwdata[smrec_pkg::BIT_TX_EVENT];
         evt_reg[smrec_pkg::BIT_DMA_EVENT] <= i_pwdata[smrec_pkg::BIT_DMA_EVENT];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sys_ie_reg <= 1'b0;
         err_ie_reg <= 1'b0;
      end else begin
         if (wr_at(smrec_pkg::OFS_SYS_IRQ_EN)) begin
            sys_ie_reg <= i_pwdata[0];
         end
         if (wr_at(smrec_pkg::OFS_ERR_IRQ_EN)) begin
            err_ie_reg <= i_pwdata[0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         scratch_reg <= smrec_pkg::SCRATCH_RESET;
      end else if (wr_at(smrec_pkg::OFS_SCRATCH)) begin
         scratch_reg <= i_pwdata; // R20
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         gate_reg <= smrec_pkg::GATE_RESET;
      end else if (wr_at(smrec_pkg::OFS_GATE_SECOND)) begin
         gate_reg <= i_pwdata & smrec_pkg::GATE_MASK; // R8 R9
      end
   end

   assign o_bank_zero_correction_enable = ecc_en_reg;
   assign o_flash_wait_states           = wait_reg;
   assign o_periph_clock_gate           = gate_reg; // R8
   // R3: wait count is not clamped; software keeps the oscillator minimum
   assign o_wake_transmit_event = evt_reg[smrec_pkg::BIT_TX_EVENT] && i_transmit_event; // R10
   assign o_receive_event =
      evt_reg[smrec_pkg::BIT_DMA_EVENT] && i_count_reached_zero; // R11

   // ----------------------------------------------------------------------
   // zeroization and peripheral reset jobs
   // ----------------------------------------------------------------------
   smrec_job_if #(.N(smrec_pkg::ZERO_W)) zero_job ();
   smrec_job_if #(.N(32))                rst_job ();
   logic [31:0] rst_active;
   logic [31:0] rst_start;

   assign zero_job.start = wr_at(smrec_pkg::OFS_MEM_ZERO) ?
                           i_pwdata[smrec_pkg::ZERO_W-1:0] : '0; // R4
   // secondary core bit triggers despite read-only listing
   assign rst_start = wr_at(smrec_pkg::OFS_RST_SECOND) ?
                      (i_pwdata & (smrec_pkg::RST_MASK |
                       (32'h1 << smrec_pkg::BIT_SECOND_CORE))) : '0; // R6 R7
   assign rst_job.start = rst_start;

   smrec_zero_engine #(.N(smrec_pkg::ZERO_W), .WORDS(ZERO_WORDS)) u_zero (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .job    (zero_job.worker),
      .o_busy (o_zero_busy)
   );

   smrec_pulse_timer #(.N(32), .CYC(smrec_pkg::RST_PULSE_CYC)) u_rst (
      .i_clk    (i_clk),
      .i_srst   (i_srst),
      .job      (rst_job.worker),
      .o_active (rst_active)
   );

   assign o_periph_reset = rst_active; // R21

   // ----------------------------------------------------------------------
   // error flags and address capture
   // ----------------------------------------------------------------------
   logic        err_flag_reg;
   logic        corr_flag_reg;
   logic [31:0] err_addr_reg;
   logic        any_err;
   logic [31:0] cache_addr;

   assign any_err = i_ram_err || i_cache_err;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         err_flag_reg <= 1'b0;
      end else if (i_ram_err) begin
         err_flag_reg <= 1'b1; // R14
      end else if (wr_at(smrec_pkg::OFS_ERR_FLAG) && i_pwdata[0]) begin
         err_flag_reg <= 1'b0; // R14
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         corr_flag_reg <= 1'b0;
      end else if (i_ram_corr) begin
         corr_flag_reg <= 1'b1; // R15
      end else if (wr_at(smrec_pkg::OFS_CORR_FLAG) && i_pwdata[0]) begin
         corr_flag_reg <= 1'b0; // R15
      end
   end

   always_comb begin
      cache_addr                            = 32'h0;
      cache_addr[smrec_pkg::BIT_TAG_ERR]    = i_cache_tag_err; // R17
      cache_addr[smrec_pkg::BIT_TAG_BANK]   = i_cache_tag_bank; // R17
      cache_addr[29:16]                     = i_cache_tag_addr; // R17
      cache_addr[smrec_pkg::BIT_DATA_ERR]   = i_cache_data_err; // R18
      cache_addr[smrec_pkg::BIT_DATA_BANK]  = i_cache_data_bank; // R18
      cache_addr[13:0]                      = i_cache_data_addr; // R18
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         err_addr_reg <= 32'h0;
      end else if (any_err && !err_flag_reg) begin // R22
         err_addr_reg <= i_ram_err ? i_ram_err_addr : cache_addr; // R19
      end
   end

   // R13 R16
   assign o_debug_lock_irq = sys_ie_reg && i_debug_locked;
   assign o_ram_error_irq  = err_ie_reg && err_flag_reg;

   // ----------------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------------
   always_comb begin
      rdata_next = 32'h0;
      case (i_paddr)
         smrec_pkg::OFS_MEM_CTRL: begin
            rdata_next[smrec_pkg::BIT_BANK0_ECC_EN] = ecc_en_reg;
            rdata_next[2:0] = wait_reg;
         end
         smrec_pkg::OFS_MEM_ZERO:    rdata_next[6:0] = o_zero_busy; // R4
         smrec_pkg::OFS_SYS_STATUS:  rdata_next[0] = i_debug_locked; // R5
         smrec_pkg::OFS_RST_SECOND:  rdata_next = rst_active; // R21
         smrec_pkg::OFS_GATE_SECOND: rdata_next = gate_reg;
         smrec_pkg::OFS_EVENT_EN:    rdata_next[2:0] = evt_reg;
         smrec_pkg::OFS_REVISION:    rdata_next[15:0] = REVISION; // R12
         smrec_pkg::OFS_SYS_IRQ_EN:  rdata_next[0] = sys_ie_reg;
         smrec_pkg::OFS_ERR_FLAG:    rdata_next[0] = err_flag_reg;
         smrec_pkg::OFS_CORR_FLAG:   rdata_next[0] = corr_flag_reg;
         smrec_pkg::OFS_ERR_IRQ_EN:  rdata_next[0] = err_ie_reg;
         smrec_pkg::OFS_ERR_ADDR:    rdata_next = err_addr_reg;
         smrec_pkg::OFS_SCRATCH:     rdata_next = scratch_reg;
         default:                    rdata_next = 32'h0;
      endcase
   end

   // read word latched in the setup cycle, shown in the access cycle
   // status bits therefore read one cycle old
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         prdata_reg <= 32'h0;
      end else if (i_psel && !i_penable) begin
         prdata_reg <= rdata_next;
      end
   end

   assign o_prdata = rd ? prdata_reg : 32'h0;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence s_zero_write;
      wr_at(smrec_pkg::OFS_MEM_ZERO) && i_pwdata[0] && !o_zero_busy[0];
   endsequence

   sequence s_pulse_run;
      o_periph_reset[1] [*4] ##1 !o_periph_reset[1];
   endsequence

   chk_ecc_enable_follows: assert property (@(posedge i_clk) disable iff (i_srst) // R1
      wr_at(smrec_pkg::OFS_MEM_CTRL) |=> o_bank_zero_correction_enable == $past(i_pwdata[16]))
      else $error("correction enable did not follow write");
   chk_wait_states: assert property (@(posedge i_clk) disable iff (i_srst) // R2
      wr_at(smrec_pkg::OFS_MEM_CTRL) |=> o_flash_wait_states == $past(i_pwdata[2:0]))
      else $error("wait states did not follow write");
   chk_zero_busy_run: assert property (@(posedge i_clk) disable iff (i_srst) // R4
      s_zero_write |=> o_zero_busy[0] [*8] ##[0:200] !o_zero_busy[0])
      else $error("zeroize busy did not run and end");
   chk_lock_status: assert property (@(posedge i_clk) disable iff (i_srst) // R5
      rd && i_paddr == smrec_pkg::OFS_SYS_STATUS |->
      o_prdata == {31'h0, $past(i_debug_locked)})
      else $error("lock status read wrong");
   chk_reset_pulse: assert property (@(posedge i_clk) disable iff (i_srst) // R6
      rst_start[1] |=> s_pulse_run)
      else $error("reset pulse length wrong");
   chk_core_reset: assert property (@(posedge i_clk) disable iff (i_srst) // R7
      wr_at(smrec_pkg::OFS_RST_SECOND) && i_pwdata[31] |=> o_periph_reset[31])
      else $error("secondary core reset not started");
   chk_gate_write: assert property (@(posedge i_clk) disable iff (i_srst) // R8
      wr_at(smrec_pkg::OFS_GATE_SECOND) |=>
      o_periph_clock_gate == ($past(i_pwdata) & smrec_pkg::GATE_MASK))
      else $error("clock gate write lost");
   chk_transmit_wake: assert property (@(posedge i_clk) disable iff (i_srst) // R10
      o_wake_transmit_event == (i_transmit_event && evt_reg[2]))
      else $error("transmit wake without enable");
   chk_receive_event: assert property (@(posedge i_clk) disable iff (i_srst) // R11
      o_receive_event == (i_count_reached_zero && evt_reg[0]))
      else $error("receive event mismatch");
   chk_error_set_wins: assert property (@(posedge i_clk) disable iff (i_srst) // R14
      i_ram_err |=> err_flag_reg)
      else $error("error flag not set");
   chk_corr_clear: assert property (@(posedge i_clk) disable iff (i_srst) // R15
      wr_at(smrec_pkg::OFS_CORR_FLAG) && i_pwdata[0] && !i_ram_corr |=> !corr_flag_reg)
      else $error("correctable flag not cleared");
   chk_addr_held: assert property (@(posedge i_clk) disable iff (i_srst) // R22
      err_flag_reg && $past(err_flag_reg) |-> $stable(err_addr_reg))
      else $error("error address overwritten");
   chk_error_irq: assert property (@(posedge i_clk) disable iff (i_srst) // R16
      i_ram_err && err_ie_reg |=> o_ram_error_irq)
      else $error("error interrupt missing");
   chk_lock_irq_enable: assert property (@(posedge i_clk) disable iff (i_srst) // R13
      wr_at(smrec_pkg::OFS_SYS_IRQ_EN) |=>
      o_debug_lock_irq == ($past(i_pwdata[0]) && i_debug_locked))
      else $error("lock interrupt enable not applied");
   chk_revision_read: assert property (@(posedge i_clk) disable iff (i_srst) // R12
      rd && i_paddr == smrec_pkg::OFS_REVISION |-> o_prdata == {16'h0, REVISION})
      else $error("revision read wrong");
   chk_error_zero_write: assert property (@(posedge i_clk) disable iff (i_srst) // R14
      wr_at(smrec_pkg::OFS_ERR_FLAG) && !i_pwdata[0] && err_flag_reg |=> err_flag_reg)
      else $error("error flag cleared by zero write");
   chk_corr_set: assert property (@(posedge i_clk) disable iff (i_srst) // R15
      i_ram_corr |=> corr_flag_reg)
      else $error("correctable flag not set");
endmodule

//--- verif/testbench.sv
// testbench: register bank driven over its register bus, readback and outputs compared
// assumes: package and design files compiled first; one 25 MHz clock
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] rst;
      logic [31:0] wd;
      logic [31:0] rb;
      logic        er;
   } smrec_row_t;
   localparam logic [15:0] REV = 16'h0042; // arbitrary revision code
   localparam int          ZW  = 16;
   logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, ram_addr = 32'h0, prdata, rd, prst, pgate;
   logic        locked = 1'b0, ram_err = 1'b0, ram_corr = 1'b0, c_err = 1'b0, tx = 1'b0;
   logic        t_err = 1'b0, t_bank = 1'b0, d_err = 1'b0, d_bank = 1'b0, count_reached_zero = 1'b0;
   logic [13:0] t_addr = 14'h0, d_addr = 14'h0;
   logic        pready, pslverr, err, ecc_en, wake_tx, rx_ev, lock_irq, err_irq;
   logic [2:0]  fws;
   logic [6:0]  zbusy;
   int          fail_count = 0;
   int          n_checks = 0;
   smrec_row_t  rows [13] = '{
      '{smrec_pkg::OFS_MEM_CTRL, 32'h5, 32'hFFFF_FFFF, 32'h0001_0007, 1'b0},
      '{smrec_pkg::OFS_MEM_CTRL, 32'h0001_0007, 32'h0001_0002, 32'h0001_0002, 1'b0},
      '{smrec_pkg::OFS_GATE_SECOND, smrec_pkg::GATE_RESET, 32'hFFFF_FFFF, 32'h8981_E206, 1'b0},
      '{smrec_pkg::OFS_GATE_SECOND, 32'h8981_E206, 32'h0, 32'h0, 1'b0},
      '{smrec_pkg::OFS_EVENT_EN, 32'h0, 32'hFFFF_FFFF, 32'h5, 1'b0},
      '{smrec_pkg::OFS_SYS_IRQ_EN, 32'h0, 32'hFFFF_FFFF, 32'h1, 1'b0},
      '{smrec_pkg::OFS_ERR_IRQ_EN, 32'h0, 32'hFFFF_FFFF, 32'h1, 1'b0},
      '{smrec_pkg::OFS_SCRATCH, 32'h0, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0},
      '{smrec_pkg::OFS_REVISION, {16'h0, REV}, 32'hFFFF_FFFF, {16'h0, REV}, 1'b0},
      '{smrec_pkg::OFS_SYS_STATUS, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0},
      '{smrec_pkg::OFS_ERR_ADDR, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0},
      '{smrec_pkg::OFS_ERR_FLAG, 32'h0, 32'h0, 32'h0, 1'b0},
      '{8'h30, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1}
   };

   always #20 clk = ~clk;

   smrec_regbank #(.REVISION(REV), .ZERO_WORDS(ZW)) i_dut (
      .i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_debug_locked(locked),
      .i_ram_err(ram_err), .i_ram_corr(ram_corr), .i_ram_err_addr(ram_addr),
      .i_cache_err(c_err), .i_cache_tag_err(t_err), .i_cache_tag_bank(t_bank),
      .i_cache_tag_addr(t_addr), .i_cache_data_err(d_err), .i_cache_data_bank(d_bank),
      .i_cache_data_addr(d_addr), .i_transmit_event(tx), .i_count_reached_zero(count_reached_zero),
      .o_bank_zero_correction_enable(ecc_en), .o_flash_wait_states(fws),
      .o_zero_busy(zbusy), .o_periph_reset(prst), .o_periph_clock_gate(pgate),
      .o_wake_transmit_event(wake_tx), .o_receive_event(rx_ev),
      .o_debug_lock_irq(lock_irq), .o_ram_error_irq(err_irq));

   // ----------------------------------------
   // bus cycles and comparison
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic pulse_err;
      @(posedge clk);
      ram_err <= 1'b1;
      @(posedge clk);
      ram_err <= 1'b0;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      #(40 * 3000);
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk(32'(fws), 32'h5);
      chk(pgate, smrec_pkg::GATE_RESET);
      chk(32'({ecc_en, lock_irq, err_irq, zbusy}), 32'h0);
      foreach (rows[i]) begin
         rdchk(rows[i].a, rows[i].rst);
         chk(32'(err), 32'(rows[i].er));
         apb(1'b1, rows[i].a, rows[i].wd);
         rdchk(rows[i].a, rows[i].rb);
         chk(32'(err), 32'(rows[i].er));
      end
      @(negedge clk);
      chk(32'({ecc_en, fws}), 32'hA);
      chk(pgate, 32'h0);
      $display("test table done");
      @(posedge clk);
      tx <= 1'b1;
      count_reached_zero <= 1'b1;
      @(negedge clk);
      chk(32'({wake_tx, rx_ev}), 32'h3);
      apb(1'b1, smrec_pkg::OFS_EVENT_EN, 32'h0);
      @(negedge clk);
      chk(32'({wake_tx, rx_ev}), 32'h0);
      @(posedge clk);
      locked <= 1'b1;
      rdchk(smrec_pkg::OFS_SYS_STATUS, 32'h1);
      chk(32'(lock_irq), 32'h1);
      apb(1'b1, smrec_pkg::OFS_SYS_IRQ_EN, 32'h0);
      @(negedge clk);
      chk(32'(lock_irq), 32'h0);
      $display("test events and lock done");
      apb(1'b1, smrec_pkg::OFS_MEM_ZERO, 32'h7F);
      rdchk(smrec_pkg::OFS_MEM_ZERO, 32'h7F);
      @(negedge clk);
      chk(32'(zbusy), 32'h7F);
      repeat (ZW + 2) @(posedge clk);
      rdchk(smrec_pkg::OFS_MEM_ZERO, 32'h0);
      apb(1'b1, smrec_pkg::OFS_RST_SECOND, 32'hFFFF_FFFF);
      rdchk(smrec_pkg::OFS_RST_SECOND, 32'h8319_0E83);
      @(negedge clk);
      chk(prst, 32'h8319_0E83);
      repeat (6) @(posedge clk);
      rdchk(smrec_pkg::OFS_RST_SECOND, 32'h0);
      chk(prst, 32'h0);
      $display("test zeroize and resets done");
      ram_addr <= 32'h2000_1234;
      pulse_err();
      ram_addr <= 32'h2000_5678;
      pulse_err();
      rdchk(smrec_pkg::OFS_ERR_FLAG, 32'h1);
      rdchk(smrec_pkg::OFS_ERR_ADDR, 32'h2000_1234);
      chk(32'(err_irq), 32'h1);
      apb(1'b1, smrec_pkg::OFS_ERR_FLAG, 32'h0);
      rdchk(smrec_pkg::OFS_ERR_FLAG, 32'h1);
      apb(1'b1, smrec_pkg::OFS_ERR_FLAG, 32'h1);
      rdchk(smrec_pkg::OFS_ERR_FLAG, 32'h0);
      chk(32'(err_irq), 32'h0);
      {c_err, t_err, t_bank, d_err, d_bank} <= 5'h1E;
      t_addr <= 14'h1ABC;
      d_addr <= 14'h0123;
      @(posedge clk);
      c_err <= 1'b0;
      rdchk(smrec_pkg::OFS_ERR_ADDR, 32'hDABC_8123);
      apb(1'b1, smrec_pkg::OFS_ERR_IRQ_EN, 32'h0);
      pulse_err();
      rdchk(smrec_pkg::OFS_ERR_FLAG, 32'h1);
      chk(32'(err_irq), 32'h0);
      @(posedge clk);
      ram_corr <= 1'b1;
      @(posedge clk);
      ram_corr <= 1'b0;
      rdchk(smrec_pkg::OFS_CORR_FLAG, 32'h1);
      apb(1'b1, smrec_pkg::OFS_CORR_FLAG, 32'h1);
      rdchk(smrec_pkg::OFS_CORR_FLAG, 32'h0);
      $display("test error capture done");
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      rdchk(smrec_pkg::OFS_SCRATCH, 32'h0);
      rdchk(smrec_pkg::OFS_MEM_CTRL, 32'h5);
      rdchk(smrec_pkg::OFS_ERR_FLAG, 32'h0);
      $display("test second reset done");
      complete_run();
   end
endmodule
